// ===== pkg/flash_ctrl_pkg.sv
// Purpose: shared constants for the flash access and program/erase controller
// Assumes: 100 MHz system clock, flash clock enable arriving as a tick input
// Notes:   durations are counted in flash clock ticks
package flash_ctrl_pkg;
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned NUM_MODULES     = 2;
    localparam int unsigned WAIT_W          = 4;
    localparam logic [3:0]  WAIT_RESET      = 4'h4;    // safe for any clock
    localparam int unsigned FLASH_TICK_KHZ  = 1000;    // flash clock rate
    localparam int unsigned ERASE_US        = 8000;    // 8.0 ms longest
    localparam int unsigned PROG_US         = 3500;    // 3.5 ms longest
    localparam int unsigned ERASE_TICKS     = (ERASE_US * FLASH_TICK_KHZ) / 1000;
    localparam int unsigned PROG_TICKS      = (PROG_US * FLASH_TICK_KHZ) / 1000;
    localparam int unsigned SEQ_OVERHEAD    = 2;       // system cycles of state machine
    localparam int unsigned PAR_LIMIT_ONE   = 2;       // reads from at most one module
    localparam int unsigned PAR_LIMIT_MANY  = 1;       // reads spread over modules
    localparam logic [1:0]  OP_PROGRAM      = 2'h1;
    localparam logic [1:0]  OP_ERASE        = 2'h2;
    localparam logic [31:0] ERASED_WORD     = 32'hffffffff;
endpackage : flash_ctrl_pkg

// ===== hw/flash_op_timer.sv
// Purpose: one program/erase sequencer per flash module
// Assumes: tick is a one-cycle flash clock enable in the system domain
// Notes:   done pulses one cycle after the count runs out
`timescale 1ns/10ps
`default_nettype none
module flash_op_timer #(
    parameter int unsigned ERASE_TICKS = flash_ctrl_pkg::ERASE_TICKS,
    parameter int unsigned PROG_TICKS  = flash_ctrl_pkg::PROG_TICKS
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // control
    input  wire logic       start,
    input  wire logic [1:0] op,
    input  wire logic       tick,
    // status
    output logic            busy,
    output logic            done
);
    typedef enum logic [1:0] {T_IDLE, T_SETUP, T_RUN, T_FINISH} tstate_t;
    tstate_t     state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic        done_r, done_nxt;

    // sequencing: setup overhead, flash clock count, wrap-up cycle
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        case (state_r)
            T_IDLE: begin
                if (start) begin
                    state_nxt = T_SETUP;
                    cnt_nxt   = (op == flash_ctrl_pkg::OP_ERASE) ? 32'(ERASE_TICKS) : 32'(PROG_TICKS);
                end
            end
            T_SETUP: state_nxt = T_RUN;
            T_RUN: begin
                if (tick) begin
                    cnt_nxt = cnt_r - 32'h1;
                    if (cnt_r <= 32'h1) state_nxt = T_FINISH;
                end
            end
            T_FINISH: begin
                state_nxt = T_IDLE;
                done_nxt  = 1'b1;
            end
            default: state_nxt = T_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= T_IDLE;
            cnt_r   <= 32'h0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
        end
    end

    assign busy = (state_r != T_IDLE);
    assign done = done_r;
endmodule : flash_op_timer
`default_nettype wire

// ===== hw/flash_access_program_control.sv
// Purpose: flash read wait states and program/erase scheduling over modules
// Assumes: read and op requests come from logic on clk_sys; tick from a pin
// Notes:   outputs are all registered; flash arrays themselves sit outside
`timescale 1ns/10ps
`default_nettype none
module flash_access_program_control #(
    parameter int unsigned NUM_MODULES = flash_ctrl_pkg::NUM_MODULES,
    parameter int unsigned ERASE_TICKS = flash_ctrl_pkg::ERASE_TICKS,
    parameter int unsigned PROG_TICKS  = flash_ctrl_pkg::PROG_TICKS
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // memory bus read side
    input  wire logic                   rd_req,
    input  wire logic                   rd_seq,
    input  wire logic [NUM_MODULES-1:0] rd_module,
    input  wire logic [3:0]             flash_wait_cycles,
    output logic                        rd_ready_r,
    // program/erase request side
    input  wire logic                   op_req,
    input  wire logic [1:0]             op_kind,
    input  wire logic [NUM_MODULES-1:0] op_module,
    output logic                        op_accept_r,
    output logic                        op_reject_r,
    // flash clock enable from outside domain
    input  wire logic                   flash_tick_in,
    // status
    output logic [NUM_MODULES-1:0]      module_busy_r,
    output logic [NUM_MODULES-1:0]      op_done_r,
    output logic                        protect_on_r
);
    function automatic int unsigned popcount(input logic [NUM_MODULES-1:0] v);
        int unsigned n;
        n = 0;
        for (int i = 0; i < NUM_MODULES; i++) n += int'(v[i]);
        return n;
    endfunction : popcount

    // tick synchroniser and edge detect
    logic tick_s1_r, tick_s2_r, tick_s3_r, tick_pulse;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_s3_r <= 1'b0;
        end else begin
            tick_s1_r <= flash_tick_in;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
        end
    end
    assign tick_pulse = tick_s2_r & ~tick_s3_r;

    // read wait counter
    logic [3:0] wait_r, wait_nxt;
    logic       rd_act_r, rd_act_nxt, rd_ready_nxt;
    always_comb begin
        wait_nxt     = wait_r;
        rd_act_nxt   = rd_act_r;
        rd_ready_nxt = 1'b0;
        if (!rd_act_r) begin
            if (rd_req) begin
                if (rd_seq) begin
                    rd_ready_nxt = 1'b1;       // prefetch serves it
                end else if (flash_wait_cycles == 4'h0) begin
                    rd_ready_nxt = 1'b1;
                end else begin
                    rd_act_nxt = 1'b1;
                    wait_nxt   = flash_wait_cycles - 4'h1;
                end
            end
        end else if (wait_r == 4'h0) begin
            rd_act_nxt   = 1'b0;
            rd_ready_nxt = 1'b1;
        end else begin
            wait_nxt = wait_r - 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_r     <= 4'h0;
            rd_act_r   <= 1'b0;
            rd_ready_r <= 1'b0;
        end else begin
            wait_r     <= wait_nxt;
            rd_act_r   <= rd_act_nxt;
            rd_ready_r <= rd_ready_nxt;
        end
    end

    // modules read recently: last read target held until next read
    logic [NUM_MODULES-1:0] reading_r, reading_nxt;
    assign reading_nxt = rd_req ? rd_module : reading_r;

    // sequencers, one per module
    logic [NUM_MODULES-1:0] busy_w, done_w, start_w;
    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_seq
        flash_op_timer #(
            .ERASE_TICKS (ERASE_TICKS),
            .PROG_TICKS  (PROG_TICKS)
        ) u_timer (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .start   (start_w[g]),
            .op      (op_kind),
            .tick    (tick_pulse),
            .busy    (busy_w[g]),
            .done    (done_w[g])
        );
    end

    // admission of program/erase requests
    logic ok, accept_nxt, reject_nxt;
    int unsigned limit;
    always_comb begin
        limit = (popcount(reading_nxt) <= 1) ? flash_ctrl_pkg::PAR_LIMIT_ONE
                                             : flash_ctrl_pkg::PAR_LIMIT_MANY;
        ok = op_req && (popcount(op_module) == 1)
             && ((op_kind == flash_ctrl_pkg::OP_PROGRAM) || (op_kind == flash_ctrl_pkg::OP_ERASE))
             && ((op_module & reading_nxt) == '0)
             && ((op_module & busy_w) == '0)
             && (popcount(busy_w) + 1 <= limit);
        accept_nxt = ok;
        reject_nxt = op_req && !ok;
        start_w    = ok ? op_module : '0;
    end

    // status registers; no protection exists at reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reading_r     <= '0;
            op_accept_r   <= 1'b0;
            op_reject_r   <= 1'b0;
            module_busy_r <= '0;
            op_done_r     <= '0;
            protect_on_r  <= 1'b0;
        end else begin
            reading_r     <= reading_nxt;
            op_accept_r   <= accept_nxt;
            op_reject_r   <= reject_nxt;
            module_busy_r <= busy_w | start_w;
            op_done_r     <= done_w;
            protect_on_r  <= 1'b0;
        end
    end

    // checker state: cycles since a non-sequential take, so that every
    // programmed wait count is checked, not just one chosen value
    logic [4:0] chk_cnt_r, chk_cnt_nxt;
    logic [3:0] chk_wait_r, chk_wait_nxt;
    always_comb begin
        chk_cnt_nxt  = chk_cnt_r;
        chk_wait_nxt = chk_wait_r;
        if (rd_req && !rd_seq && !rd_act_r) begin
            chk_cnt_nxt  = 5'h01;
            chk_wait_nxt = flash_wait_cycles;
        end else if (chk_cnt_r == ({1'b0, chk_wait_r} + 5'h01)) begin
            chk_cnt_nxt  = 5'h00;              // answer due now, stop watching
        end else if (chk_cnt_r != 5'h00) begin
            chk_cnt_nxt  = chk_cnt_r + 5'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chk_cnt_r  <= 5'h00;
            chk_wait_r <= 4'h0;
        end else begin
            chk_cnt_r  <= chk_cnt_nxt;
            chk_wait_r <= chk_wait_nxt;
        end
    end

    // read side: prefetch answers at once, random access pays the waits
    AST_SEQ_NO_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_seq && !rd_act_r) |=> rd_ready_r) else $error("seq read delayed");
    AST_NONSEQ_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_req && !rd_seq && !rd_act_r && flash_wait_cycles == flash_ctrl_pkg::WAIT_RESET)
        |=> !rd_ready_r [*4] ##1 rd_ready_r) else $error("wait count wrong");
    AST_WAIT_ANY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (chk_cnt_r != 5'h00) |-> (rd_ready_r == (chk_cnt_r == ({1'b0, chk_wait_r} + 5'h01))))
        else $error("read answer off its wait count");
    // admission: reader, busy and parallel limits
    AST_NO_OP_ON_READER: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (|(start_w & reading_nxt)) == 1'b0) else $error("op on read module");
    AST_PAR_LIMIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        popcount(busy_w) <= 2) else $error("too many parallel ops");
    AST_BUSY_REJECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (op_req && |(op_module & busy_w)) |=> op_reject_r && !op_accept_r) else $error("busy not rejected");
    AST_BAD_REQ_REJECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (op_req && (popcount(op_module) != 1)) |=> (op_reject_r && !op_accept_r))
        else $error("malformed op accepted");
    AST_ANSWER_EXCL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(op_accept_r && op_reject_r)) else $error("accept and reject together");
    AST_M1_WHILE_M0: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (op_req && op_module == 2'b10 && reading_nxt == 2'b01 && busy_w == '0
         && op_kind == flash_ctrl_pkg::OP_PROGRAM) |=> op_accept_r) else $error("module one refused");
    // sequencer status
    AST_BUSY_AFTER_ACCEPT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_accept_r |-> (module_busy_r != '0)) else $error("busy missing");
    AST_DONE_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (op_done_r & $past(op_done_r)) == '0) else $error("done longer than one cycle");
    AST_NO_PROTECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !protect_on_r) else $error("protection set");
    COV_ACCEPT: cover property (@(posedge clk_sys) disable iff (!rst_n) op_accept_r);
    COV_SEQ: cover property (@(posedge clk_sys) disable iff (!rst_n) (rd_req && rd_seq) ##1 rd_ready_r);
    COV_REJECT: cover property (@(posedge clk_sys) disable iff (!rst_n) op_reject_r);
    COV_DONE: cover property (@(posedge clk_sys) disable iff (!rst_n) |op_done_r);
    COV_WAIT: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_act_r ##1 rd_ready_r);
endmodule : flash_access_program_control
`default_nettype wire

// ===== test/flash_read_master.sv
// Purpose: code-fetch side model issuing flash reads
// Assumes: requests launched at the falling edge, one read at a time
// Notes:   released lines show the inverse, never a stale value
`timescale 1ns/10ps
`default_nettype none
module flash_read_master (
    // clock
    input  wire logic       clk_sys,
    // read side
    output logic            rd_req,
    output logic            rd_seq,
    output logic [1:0]      rd_module,
    input  wire logic       rd_ready_r
);
    // idle bus at time zero
    initial begin
        rd_req    = 1'b0;
        rd_seq    = 1'b0;
        rd_module = 2'h0;
    end
    // one read, n returns cycles from take to answer
    task automatic read(input logic seq, input logic [1:0] mdl, output int n);
        @(negedge clk_sys);
        rd_req    = 1'b1;
        rd_seq    = seq;
        rd_module = mdl;
        @(negedge clk_sys);
        rd_req    = 1'b0;
        rd_seq    = ~seq;
        rd_module = ~mdl;  // stale value would hide a bad capture
        // answer stands one cycle from its launch edge, so look mid-cycle
        n = 1;
        while (rd_ready_r !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : read
endmodule : flash_read_master
`default_nettype wire

// ===== test/testbench.sv
// Purpose: random and corner checks of flash read waits and op scheduling
// Assumes: short tick counts, flash tick period of ten system cycles
// Notes:   bounds on durations allow for tick phase and synchroniser
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    localparam int unsigned ERS = 4;
    localparam int unsigned PRG = 2;
    localparam int TICK_CYC = 10;  // flash tick period in system cycles
    logic clk_sys, rst_n, rd_req, rd_seq, rd_ready_r, op_req, op_accept_r;
    logic op_reject_r, flash_tick_in, protect_on_r;
    logic [1:0] rd_module, op_kind, op_module, module_busy_r, op_done_r;
    logic [3:0] flash_wait_cycles;
    int num_errors, check_count, n, w, wmin;
    time t_acc [2];
    logic s;
    flash_access_program_control #(.ERASE_TICKS(ERS), .PROG_TICKS(PRG))
        i_flash_access_program_control (.clk_sys, .rst_n, .rd_req, .rd_seq,
        .rd_module, .flash_wait_cycles, .rd_ready_r, .op_req, .op_kind,
        .op_module, .op_accept_r, .op_reject_r, .flash_tick_in,
        .module_busy_r, .op_done_r, .protect_on_r);
    flash_read_master i_flash_read_master (.clk_sys, .rd_req, .rd_seq,
        .rd_module, .rd_ready_r);
    // clock and slow flash tick
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        flash_tick_in = 1'b0;
        forever #50 flash_tick_in = ~flash_tick_in;
    end
    function automatic int exp_lat(logic sq, int wc);
        return (sq || wc == 0) ? 1 : wc + 1;
    endfunction : exp_lat
    // lowest wait count software may program at a given clock
    function automatic int min_wait(int mhz);
        return (mhz <= 8) ? 1 : (mhz <= 13) ? 2 : (mhz <= 17) ? 3 : 4;
    endfunction : min_wait
    // earliest done: setup, first tick, remaining ticks, two register stages
    function automatic int done_lo(int t);
        return int'(flash_ctrl_pkg::SEQ_OVERHEAD) + (t - 1) * TICK_CYC + 2;
    endfunction : done_lo
    // one op request, answer checked in the cycle after take
    task automatic op(logic [1:0] k, logic [1:0] m, logic acc);
        @(negedge clk_sys);
        op_req    = 1'b1;
        op_kind   = k;
        op_module = m;
        @(posedge clk_sys);
        #1;
        `CHK({op_accept_r, op_reject_r}, {acc, ~acc})
        if (acc)
            t_acc[m[1]] = $time;
        @(negedge clk_sys);
        op_req    = 1'b0;
    endtask : op
    // completion time in system cycles after accept; tick phase spans one period
    task automatic wait_done(int i, int t);
        int d;
        n = 0;
        while (op_done_r[i] !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        d = int'(($time - t_acc[i]) / 10);
        `CHK(d >= done_lo(t) && d <= done_lo(t) + TICK_CYC - 1, 1'b1)
        @(posedge clk_sys);
        #1;
        `CHK(module_busy_r[i], 1'b0)
    endtask : wait_done
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // watchdog cuts a hang short
    initial begin
        #300000;
        num_errors++;
        summarize();
    end
    initial begin
        num_errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        op_req = 1'b0;
        op_kind = 2'h0;
        op_module = 2'h0;
        flash_wait_cycles = 4'h4;
        void'($urandom(7));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK({module_busy_r, op_done_r, protect_on_r}, 5'h00)
        op(flash_ctrl_pkg::OP_ERASE, 2'h1, 1'b1);
        op(flash_ctrl_pkg::OP_PROGRAM, 2'h2, 1'b1);
        `CHK(module_busy_r, 2'h3)
        op(flash_ctrl_pkg::OP_PROGRAM, 2'h1, 1'b0);
        wait_done(1, PRG);
        wait_done(0, ERS);
        wmin = min_wait(int'(flash_ctrl_pkg::CLK_MHZ));
        for (int i = 0; i < 12; i++) begin
            w = (i < 2) ? wmin : int'($urandom_range(15, wmin));
            s = (i == 0) ? 1'b1 : 1'b0;
            if (i > 1)
                s = 1'($urandom_range(0, 1));
            @(negedge clk_sys);
            flash_wait_cycles = w[3:0];
            i_flash_read_master.read(s, 2'h1, n);
            `CHK(n, exp_lat(s, w))
        end
        op(flash_ctrl_pkg::OP_ERASE, 2'h1, 1'b0);
        op(2'h0, 2'h2, 1'b0);
        op(2'h3, 2'h2, 1'b0);
        op(flash_ctrl_pkg::OP_PROGRAM, 2'h3, 1'b0);
        op(flash_ctrl_pkg::OP_PROGRAM, 2'h0, 1'b0);
        op(flash_ctrl_pkg::OP_ERASE, 2'h2, 1'b1);
        wait_done(1, ERS);
        `CHK(protect_on_r, 1'b0)
        summarize();
    end
endmodule : testbench
`default_nettype wire
